//--- shared/mq_read_pkg.sv
// Purpose: Constants and types for the multi-queue read port and status bus.
// Assumes: One clock; controller logic on the same clock.
// Notes: Operation
package mq_read_pkg;
    localparam int QUEUES = 16;
    localparam int QW = 4;
    localparam int DEV_W = 3;
    localparam int ADDR_W = 7;
    localparam int DEPTH = 16;
    localparam int PW = 4;
    localparam int CW = 5;
    localparam int WORD_W = 18;
    localparam int BYTE_W = 9;
    localparam int SECTOR_W = 8;
    localparam int PIN_W = 11;
    localparam logic [CW-1:0] DEPTH_COUNT = 5'h10;
    localparam logic [CW-1:0] AE_LEVEL = 5'h02;
    localparam logic [1:0] OWN_LAST = 2'h3;
    localparam logic [DEV_W-1:0] RESET_DEVICE = 3'h0;
    localparam logic [QW-1:0] RESET_QUEUE = 4'h0;

    typedef enum logic [1:0]
    {
        RD_RUN = 2'b00,
        RD_OLD = 2'b01,
        RD_NEW = 2'b11
    } rd_phase_type;

    typedef enum logic [1:0]
    {
        TK_IDLE = 2'b00,
        TK_START = 2'b01,
        TK_OWN = 2'b11,
        TK_WAIT = 2'b10
    } token_state_type;
endpackage : mq_read_pkg

//--- rtl/pin_sync.sv
// Purpose: Two-flop synchroniser for a group of pin inputs.
// Assumes: Each bit is an independent level.
// Notes: Only the second stage is visible outside.
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Levels
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_q <= INIT;
            sync_q <= INIT;
        end
        else
        begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign pin_out = sync_q;
endmodule : pin_sync

//--- rtl/mq_read_port.sv
// Purpose: Read port, fall-through pipeline and almost-empty status bus of a queue device.
// Assumes: Write and read controller run on ref_clk; straps and ring pins are asynchronous.
// Notes: Tri-state pins appear as value plus enable; the bench resolves the wire.
module mq_read_port
    import mq_read_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Pins and straps
    input wire logic full_reset_n,
    input wire logic flag_bus_polling_select,
    input wire logic chain_leader_select,
    input wire logic input_width_select,
    input wire logic output_width_select,
    input wire logic byte_order_select_n,
    input wire logic [DEV_W-1:0] device_id,
    input wire logic queue_clear_n,
    // Write port
    input wire logic write_queue_sel,
    input wire logic [ADDR_W-1:0] write_queue_addr,
    input wire logic write_en_n,
    input wire logic [WORD_W-1:0] write_data,
    output logic write_ready,
    // Read port
    input wire logic read_queue_sel,
    input wire logic [ADDR_W-1:0] read_queue_addr,
    input wire logic read_en_n,
    output logic [WORD_W-1:0] read_data,
    output logic read_data_oe,
    output logic output_valid_n,
    output logic output_valid_oe,
    output logic almost_empty_flag_n,
    // Status bus and ring
    input wire logic status_sector_select,
    output logic [SECTOR_W-1:0] almost_empty_status_bus,
    output logic almost_empty_status_bus_oe,
    output logic status_frame_mark,
    input wire logic token_in,
    output logic token_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and straps

    // Full reset reads as active until its pin has passed the synchroniser
    localparam logic [PIN_W-1:0] PIN_INIT = 11'h002;

    logic [PIN_W-1:0] pins_s;
    logic full_active;
    logic token_s;
    logic clear_active;
    logic token_prev_q;
    logic token_rise;
    logic polled_q;
    logic leader_q;
    logic in_x9_q;
    logic out_x9_q;
    logic little_q;
    logic [DEV_W-1:0] dev_q;

    pin_sync #(.WIDTH(PIN_W), .INIT(PIN_INIT)) u_pin_sync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .pin_in({device_id, byte_order_select_n, output_width_select, input_width_select,
                 chain_leader_select, flag_bus_polling_select, token_in, queue_clear_n,
                 full_reset_n}),
        .pin_out(pins_s)
    );

    assign full_active = ~pins_s[0];
    assign clear_active = ~pins_s[1] & ~full_active;
    assign token_s = pins_s[2];
    assign token_rise = token_s & ~token_prev_q;

    // Straps are caught while full reset is held
    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            polled_q <= 1'b0;
            leader_q <= 1'b0;
            in_x9_q <= 1'b0;
            out_x9_q <= 1'b0;
            little_q <= 1'b0;
            dev_q <= RESET_DEVICE;
            token_prev_q <= 1'b0;
        end
        else
        begin
            token_prev_q <= token_s;
            if (full_active)
            begin
                polled_q <= pins_s[3];
                leader_q <= pins_s[4];
                in_x9_q <= pins_s[5];
                out_x9_q <= pins_s[6];
                little_q <= pins_s[7];
                dev_q <= pins_s[10:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Byte packing

    function automatic logic [WORD_W-1:0] pack_pair(input logic [BYTE_W-1:0] first,
                                                   input logic [BYTE_W-1:0] second,
                                                   input logic little);
        pack_pair = little ? {second, first} : {first, second};
    endfunction : pack_pair

    function automatic logic [BYTE_W-1:0] pick_byte(input logic [WORD_W-1:0] word,
                                                   input logic second,
                                                   input logic little);
        pick_byte = (second ^ little) ? word[BYTE_W-1:0] : word[WORD_W-1:BYTE_W];
    endfunction : pick_byte

    ////////////////////////////////////////////////////////////////////////////////
    // Write side: queue select and word assembly

    logic [QW-1:0] wq_q;
    logic wq_mine_q;
    logic [BYTE_W-1:0] in_byte_q;
    logic in_half_q;
    logic write_hit;
    logic push;
    logic [WORD_W-1:0] push_word;
    logic [CW-1:0] cnt_q [QUEUES];
    logic [PW-1:0] wp_q [QUEUES];
    logic [PW-1:0] rp_q [QUEUES];
    logic [WORD_W-1:0] mem [QUEUES*DEPTH];

    assign write_ready = cnt_q[wq_q] != DEPTH_COUNT;
    assign write_hit = ~write_en_n & wq_mine_q & write_ready & ~clear_active & ~full_active;
    assign push = write_hit & (~in_x9_q | in_half_q);
    assign push_word = in_x9_q ? pack_pair(in_byte_q, write_data[BYTE_W-1:0], little_q)
                               : write_data;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wq_q <= RESET_QUEUE;
            wq_mine_q <= 1'b0;
            in_byte_q <= '0;
            in_half_q <= 1'b0;
        end
        else if (full_active)
        begin
            wq_q <= RESET_QUEUE;
            wq_mine_q <= dev_q == RESET_DEVICE;
            in_half_q <= 1'b0;
        end
        else
        begin
            if (write_queue_sel)
            begin
                wq_q <= write_queue_addr[QW-1:0];
                wq_mine_q <= write_queue_addr[ADDR_W-1:QW] == dev_q;
                in_half_q <= 1'b0;
            end
            else if (write_hit && in_x9_q)
            begin
                in_half_q <= ~in_half_q;
                in_byte_q <= write_data[BYTE_W-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem[{wq_q, wp_q[wq_q]}] <= push_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read side: fall-through pipeline

    rd_phase_type phase_q;
    rd_phase_type phase_d;
    logic [QW-1:0] cur_q;
    logic cur_mine_q;
    logic [QW-1:0] new_q;
    logic new_mine_q;
    logic [WORD_W-1:0] out_word_q;
    logic out_half_q;
    logic ov_n_q;
    logic own_out_q;
    logic ae_flag_n_q;
    logic cur_avail;
    logic want;
    logic half_step;
    logic pop;
    logic read_empty;

    assign cur_avail = cur_mine_q & (cnt_q[cur_q] != '0);
    // Forced delivery in both switch cycles, else on read enable or when invalid
    assign want = (phase_q != RD_RUN) | ~read_en_n | ov_n_q;
    assign half_step = out_x9_q & ~out_half_q & ~ov_n_q & (phase_q == RD_RUN) & ~read_en_n;
    assign pop = want & cur_avail & ~half_step & ~clear_active & ~full_active;
    assign read_empty = want & ~cur_avail & ~half_step & ~full_active;

    always_comb
    begin
        case (phase_q)
            RD_RUN: phase_d = RD_RUN;
            RD_OLD: phase_d = RD_NEW;
            RD_NEW: phase_d = RD_RUN;
            default: phase_d = RD_RUN;
        endcase
        if (read_queue_sel)
        begin
            phase_d = RD_OLD;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            phase_q <= RD_RUN;
            cur_q <= RESET_QUEUE;
            cur_mine_q <= 1'b0;
            new_q <= RESET_QUEUE;
            new_mine_q <= 1'b0;
            own_out_q <= 1'b0;
        end
        else if (full_active)
        begin
            phase_q <= RD_RUN;
            cur_q <= RESET_QUEUE;
            cur_mine_q <= dev_q == RESET_DEVICE;
            own_out_q <= dev_q == RESET_DEVICE;
        end
        else
        begin
            phase_q <= phase_d;
            if (read_queue_sel)
            begin
                new_q <= read_queue_addr[QW-1:0];
                new_mine_q <= read_queue_addr[ADDR_W-1:QW] == dev_q;
            end
            if (phase_q == RD_OLD)
            begin
                cur_q <= new_q;
                cur_mine_q <= new_mine_q;
            end
            if (phase_q == RD_NEW)
            begin
                own_out_q <= cur_mine_q;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            out_word_q <= '0;
            out_half_q <= 1'b0;
            ov_n_q <= 1'b1;
            ae_flag_n_q <= 1'b0;
        end
        else
        begin
            ae_flag_n_q <= ~cur_mine_q | (cnt_q[cur_q] > AE_LEVEL);
            if (full_active)
            begin
                ov_n_q <= 1'b1;
                out_half_q <= 1'b0;
            end
            else if (pop)
            begin
                out_word_q <= mem[{cur_q, rp_q[cur_q]}];
                out_half_q <= 1'b0;
                ov_n_q <= 1'b0;
            end
            else if (half_step)
            begin
                out_half_q <= 1'b1;
            end
            else if (read_empty)
            begin
                ov_n_q <= 1'b1;
            end
        end
    end

    assign read_data = out_x9_q
                     ? {{(WORD_W-BYTE_W){1'b0}}, pick_byte(out_word_q, out_half_q, little_q)}
                     : out_word_q;
    assign read_data_oe = own_out_q;
    assign output_valid_n = ov_n_q;
    assign output_valid_oe = own_out_q;
    assign almost_empty_flag_n = ae_flag_n_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Queue pointers and counts

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < QUEUES; i++)
            begin
                cnt_q[i] <= '0;
                wp_q[i] <= '0;
                rp_q[i] <= '0;
            end
        end
        else
        begin
            for (int i = 0; i < QUEUES; i++)
            begin
                if (full_active || (clear_active && cur_q == QW'(i)))
                begin
                    cnt_q[i] <= '0;
                    wp_q[i] <= '0;
                    rp_q[i] <= '0;
                end
                else
                begin
                    if (push && wq_q == QW'(i))
                    begin
                        wp_q[i] <= wp_q[i] + 1'b1;
                    end
                    if (pop && cur_q == QW'(i))
                    begin
                        rp_q[i] <= rp_q[i] + 1'b1;
                    end
                    if ((push && wq_q == QW'(i)) && !(pop && cur_q == QW'(i)))
                    begin
                        cnt_q[i] <= cnt_q[i] + 1'b1;
                    end
                    else if (!(push && wq_q == QW'(i)) && (pop && cur_q == QW'(i)))
                    begin
                        cnt_q[i] <= cnt_q[i] - 1'b1;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Almost-empty status bus and token ring

    token_state_type tk_q;
    logic [QUEUES-1:0] ae_vec_q;
    logic [1:0] span_q;
    logic sector_q;
    logic sector_d;
    logic own_d;
    logic [SECTOR_W-1:0] bus_q;
    logic bus_oe_q;
    logic mark_q;
    logic token_out_q;

    assign own_d = (tk_q == TK_START && leader_q && polled_q)
                 || (tk_q == TK_OWN && span_q != OWN_LAST)
                 || (tk_q == TK_WAIT && token_rise);
    assign sector_d = polled_q ? (tk_q == TK_OWN && span_q != OWN_LAST && !sector_q)
                               : status_sector_select;

    always_ff @(posedge ref_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tk_q <= TK_IDLE;
            span_q <= '0;
            sector_q <= 1'b0;
            token_out_q <= 1'b0;
            ae_vec_q <= '1;
            bus_q <= '1;
            bus_oe_q <= 1'b0;
            mark_q <= 1'b0;
        end
        else if (full_active)
        begin
            tk_q <= TK_START;
            span_q <= '0;
            sector_q <= 1'b0;
            token_out_q <= 1'b0;
            bus_oe_q <= 1'b0;
            mark_q <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < QUEUES; i++)
            begin
                ae_vec_q[i] <= cnt_q[i] > AE_LEVEL;
            end
            sector_q <= sector_d;
            bus_q <= sector_d ? ae_vec_q[QUEUES-1:SECTOR_W] : ae_vec_q[SECTOR_W-1:0];
            if (polled_q)
            begin
                tk_q <= own_d ? TK_OWN : TK_WAIT;
                span_q <= (tk_q == TK_OWN && own_d) ? span_q + 1'b1 : 2'h0;
                token_out_q <= tk_q == TK_OWN && span_q == OWN_LAST;
                bus_oe_q <= own_d;
                mark_q <= own_d && !sector_d;
            end
            else
            begin
                tk_q <= TK_WAIT;
                token_out_q <= 1'b0;
                bus_oe_q <= 1'b1;
                mark_q <= 1'b0;
            end
        end
    end

    assign almost_empty_status_bus = bus_q;
    assign almost_empty_status_bus_oe = bus_oe_q;
    assign status_frame_mark = mark_q;
    assign token_out = token_out_q;
endmodule : mq_read_port

//--- testbench/mq_read_port_sva.sv
// Purpose: Port checker for the queue read port.
// Assumes: Straps steady between full resets; selects at least two cycles apart.
// Notes: Bound to every read port instance.
module mq_read_port_sva
    import mq_read_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic full_reset_n,
    input wire logic flag_bus_polling_select,
    input wire logic chain_leader_select,
    input wire logic [DEV_W-1:0] device_id,
    input wire logic read_queue_sel,
    input wire logic [ADDR_W-1:0] read_queue_addr,
    input wire logic read_en_n,
    input wire logic [WORD_W-1:0] read_data,
    input wire logic read_data_oe,
    input wire logic output_valid_n,
    input wire logic almost_empty_status_bus_oe,
    input wire logic status_frame_mark,
    input wire logic token_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wire sel_here = read_queue_sel && read_queue_addr[6:4] == device_id && full_reset_n;
    wire sel_away = read_queue_sel && read_queue_addr[6:4] != device_id && full_reset_n;
    wire frame_start = status_frame_mark && almost_empty_status_bus_oe;
    property p_mark_owned;
        status_frame_mark |-> almost_empty_status_bus_oe;
    endproperty
    a_mark_owned: assert property (p_mark_owned) else $error("mark without drive");
    property p_mark_alt;
        (status_frame_mark ##1 almost_empty_status_bus_oe) |-> !status_frame_mark;
    endproperty
    a_mark_alt: assert property (p_mark_alt) else $error("sectors not alternating");
    property p_own_span;
        $rose(almost_empty_status_bus_oe) && status_frame_mark
            |-> almost_empty_status_bus_oe [*4] ##1 !almost_empty_status_bus_oe;
    endproperty
    a_own_span: assert property (p_own_span) else $error("ownership span wrong");
    property p_token_after;
        $rose(almost_empty_status_bus_oe) && status_frame_mark |-> ##[3:5] token_out;
    endproperty
    a_token_after: assert property (p_token_after) else $error("token not passed");
    property p_token_pulse;
        token_out |=> !token_out;
    endproperty
    a_token_pulse: assert property (p_token_pulse) else $error("token too long");
    property p_leader_start;
        $rose(full_reset_n) && chain_leader_select && flag_bus_polling_select
            |-> ##[1:6] frame_start;
    endproperty
    a_leader_start: assert property (p_leader_start) else $error("leader late");
    property p_hold;
        ($past(read_en_n) && !$past(output_valid_n) && $past(full_reset_n)
            && $past(full_reset_n, 4) && !$past(read_queue_sel, 2)
            && !$past(read_queue_sel, 3)) |-> $stable(read_data);
    endproperty
    a_hold: assert property (p_hold) else $error("word changed while idle");
    property p_empty_hold;
        $rose(output_valid_n) && full_reset_n |-> $stable(read_data);
    endproperty
    a_empty_hold: assert property (p_empty_hold) else $error("last word lost");
    property p_oe_here;
        sel_here |-> ##[2:3] read_data_oe;
    endproperty
    a_oe_here: assert property (p_oe_here) else $error("bus not taken");
    property p_oe_away;
        sel_away |-> ##[2:3] !read_data_oe;
    endproperty
    a_oe_away: assert property (p_oe_away) else $error("bus not floated");
    c_token: cover property ($rose(token_out));
    c_empty: cover property ($rose(output_valid_n));
    c_switch: cover property (sel_here ##2 !output_valid_n);
endmodule : mq_read_port_sva
bind mq_read_port mq_read_port_sva chk_u (.ref_clk, .rstn, .full_reset_n,
    .flag_bus_polling_select, .chain_leader_select, .device_id, .read_queue_sel,
    .read_queue_addr, .read_en_n, .read_data, .read_data_oe, .output_valid_n,
    .almost_empty_status_bus_oe, .status_frame_mark, .token_out);

//--- testbench/mq_far_side.sv
// Purpose: Board side of one device: token loop and resolved tri-state wires.
// Assumes: No pulls on the buses.
// Notes: A released wire shows the inverse of its last driven value.
module mq_far_side
    import mq_read_pkg::*;
(
    input wire logic ref_clk,
    input wire logic token_out,
    output logic token_in,
    input wire logic [SECTOR_W-1:0] status_drive,
    input wire logic status_oe,
    output logic [SECTOR_W-1:0] status_wire,
    input wire logic [WORD_W-1:0] data_drive,
    input wire logic data_oe,
    output logic [WORD_W-1:0] data_wire
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [SECTOR_W-1:0] status_last = '0;
    logic [WORD_W-1:0] data_last = '0;
    assign token_in = token_out;
    assign status_wire = status_oe ? status_drive : ~status_last;
    assign data_wire = data_oe ? data_drive : ~data_last;
    always @(posedge ref_clk)
    begin
        if (status_oe)
            status_last <= status_drive;
        if (data_oe)
            data_last <= data_drive;
    end
endmodule : mq_far_side

//--- testbench/tb_multi_queue_read_port_status_bus.sv
// Purpose: Self-checking bench for the queue read port and status bus.
// Assumes: Single leader device, token looped on the board.
// Notes: Controller drives on rising edges; checks 1 ns after the edge.
module tb_multi_queue_read_port_status_bus;
    timeunit 1ns;
    timeprecision 1ps;
    import mq_read_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic full_reset_n = 1'b0;
    logic flag_bus_polling_select = 1'b1;
    logic chain_leader_select = 1'b1;
    logic input_width_select = 1'b0;
    logic output_width_select = 1'b0;
    logic byte_order_select_n = 1'b0;
    logic [DEV_W-1:0] device_id = '0;
    logic queue_clear_n = 1'b1;
    logic write_queue_sel = 1'b0;
    logic [ADDR_W-1:0] write_queue_addr = '0;
    logic write_en_n = 1'b1;
    logic [WORD_W-1:0] write_data = '0;
    logic read_queue_sel = 1'b0;
    logic [ADDR_W-1:0] read_queue_addr = '0;
    logic read_en_n = 1'b1;
    logic status_sector_select = 1'b0;
    logic token_in, token_out, write_ready, read_data_oe, output_valid_n, output_valid_oe;
    logic almost_empty_flag_n, almost_empty_status_bus_oe, status_frame_mark;
    logic [WORD_W-1:0] read_data, data_wire;
    logic [SECTOR_W-1:0] almost_empty_status_bus, status_wire;
    int miscompares = 0;
    int samples_checked = 0;
    int i;
    always #2 ref_clk = ~ref_clk;
    mq_read_port dut_u (.ref_clk, .rstn, .full_reset_n, .flag_bus_polling_select,
        .chain_leader_select, .input_width_select, .output_width_select,
        .byte_order_select_n, .device_id, .queue_clear_n, .write_queue_sel,
        .write_queue_addr, .write_en_n, .write_data, .write_ready, .read_queue_sel,
        .read_queue_addr, .read_en_n, .read_data, .read_data_oe, .output_valid_n,
        .output_valid_oe, .almost_empty_flag_n, .status_sector_select,
        .almost_empty_status_bus, .almost_empty_status_bus_oe, .status_frame_mark,
        .token_in, .token_out);
    mq_far_side far_u (.ref_clk, .token_out, .token_in,
        .status_drive(almost_empty_status_bus), .status_oe(almost_empty_status_bus_oe),
        .status_wire, .data_drive(read_data), .data_oe(read_data_oe), .data_wire);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : complete_run
    task automatic look(input string what, input logic [WORD_W-1:0] exp, got);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : look
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick
    task automatic full_rst(input logic poll_be, input logic ow);
        @(posedge ref_clk);
        full_reset_n <= 1'b0;
        flag_bus_polling_select <= poll_be;
        byte_order_select_n <= poll_be;
        output_width_select <= ow;
        repeat (4) @(posedge ref_clk);
        full_reset_n <= 1'b1;
        tick(4);
    endtask : full_rst
    task automatic wr(input logic [ADDR_W-1:0] q, input logic [WORD_W-1:0] w, input int n);
        @(posedge ref_clk);
        write_queue_sel <= 1'b1;
        write_queue_addr <= q;
        @(posedge ref_clk);
        write_queue_sel <= 1'b0;
        repeat (n)
        begin
            write_en_n <= 1'b0;
            write_data <= w;
            w = w + 18'h00001;
            @(posedge ref_clk);
        end
        write_en_n <= 1'b1;
        #1;
    endtask : wr
    task automatic rsel(input logic [ADDR_W-1:0] q);
        @(posedge ref_clk);
        read_queue_sel <= 1'b1;
        read_queue_addr <= q;
        @(posedge ref_clk);
        read_queue_sel <= 1'b0;
        #1;
    endtask : rsel
    task automatic pop;
        @(posedge ref_clk);
        read_en_n <= 1'b0;
        @(posedge ref_clk);
        read_en_n <= 1'b1;
        #1;
    endtask : pop
    task automatic wait_frame;
        int n;
        n = 0;
        while ((status_frame_mark & almost_empty_status_bus_oe) !== 1'b1 && n < 40)
        begin
            tick(1);
            n++;
        end
        if (n == 40)
        begin
            miscompares++;
            complete_run;
        end
    endtask : wait_frame
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        full_rst(1'b1, 1'b0);
        look("leader drive", 1'b1, almost_empty_status_bus_oe);
        wait_frame;
        tick(4);
        wait_frame;
        for (i = 0; i < 4; i++)
        begin
            look("frame mark", (i % 2) == 0, status_frame_mark);
            look("status bus", 8'h00, status_wire);
            tick(1);
        end
        look("bus drive", 1'b0, almost_empty_status_bus_oe);
        look("token", 1'b1, token_out);
        look("floating bus", 8'hff, status_wire);
        rsel(7'h01);
        wr(7'h01, 18'h00101, 3);
        look("first word", 18'h00101, read_data);
        look("valid", 1'b0, output_valid_n);
        tick(2);
        look("held word", 18'h00101, read_data);
        pop;
        look("read 2", 18'h00102, read_data);
        pop;
        pop;
        look("last word", 18'h00103, read_data);
        look("empty", 1'b1, output_valid_n);
        wr(7'h02, 18'h00201, 2);
        wr(7'h01, 18'h00111, 3);
        rsel(7'h02);
        tick(1);
        look("old next", 18'h00112, read_data);
        tick(1);
        look("new first", 18'h00201, read_data);
        look("new valid", 1'b0, output_valid_n);
        tick(2);
        look("held new", 18'h00201, read_data);
        pop;
        look("new second", 18'h00202, read_data);
        rsel(7'h10);
        tick(2);
        look("foreign oe", 1'b0, read_data_oe);
        look("foreign valid oe", 1'b0, output_valid_oe);
        look("floating data", 18'h3fdfd, data_wire);
        rsel(7'h01);
        tick(2);
        look("own oe", 1'b1, read_data_oe);
        look("own valid oe", 1'b1, output_valid_oe);
        look("back word", 18'h00113, data_wire);
        wr(7'h01, 18'h00121, 6);
        tick(3);
        look("not almost empty", 1'b1, almost_empty_flag_n);
        @(posedge ref_clk);
        queue_clear_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        queue_clear_n <= 1'b1;
        tick(6);
        look("cleared", 1'b0, almost_empty_flag_n);
        look("room", 1'b1, write_ready);
        wr(7'h03, 18'h00301, 16);
        look("full queue", 1'b0, write_ready);
        wait_frame;
        look("sector 0", 8'h08, status_wire);
        tick(1);
        look("sector 1", 8'h00, status_wire);
        for (i = 0; i < 2; i++)
        begin
            full_rst(i[0], 1'b1);
            if (i == 0)
                look("addressed mark", 1'b0, status_frame_mark);
            else
                wait_frame;
            look("status drive", 1'b1, almost_empty_status_bus_oe);
            wr(7'h00, 18'h2a5c3, 1);
            tick(1);
            look("first byte", i ? 18'h001c3 : 18'h00152, read_data);
            pop;
            look("second byte", i ? 18'h00152 : 18'h001c3, read_data);
        end
        complete_run;
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        complete_run;
    end
endmodule : tb_multi_queue_read_port_status_bus
